// ---- shared/option_cfg_pkg.sv ----
// Constants, field layout and register map of the option byte decoder
// Overview of operation
// - First byte bit 7 set makes halt entry with a running watchdog reset the chip.
// - First byte bit 6 clear enables the watchdog by hardware, set leaves it to software.
// - Field 5:4 of the first byte turns supply detection off (11) or picks low, medium or high threshold (10, 01, 00).
// - Field 3:2 of the first byte sets sector zero to 0.5, 1, 2 or 4 kilobytes.
// - Read-out protection set blocks program memory access outside user and in-application modes.
// - Erasing the option bytes with read-out protection set erases the whole program memory first.
// - Write protection set permanently refuses erase or program of program memory and of that bit.
// - Second byte bit 7 routes port C interrupts to the second vector (1) or the first vector (0).
// - Second byte bit 6 clear enables the clock filter and backup oscillator, set disables them.
// - Field 5:4 of the second byte picks resonator, reserved, internal RC or external clock.
// - Option bytes have no memory-mapped address and are reached only in programming mode.
// - Blank parts hold FFh program memory and option bytes that select the internal RC oscillator.
// - Mask-coded parts carry fixed option values that the user cannot program.
// - Field 3:1 of the second byte picks the band: 1xx very low power, 000 to 011 rising ranges.
package option_cfg_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_OPT0    = 8'h04;
  localparam logic [7:0] ADDR_OPT1    = 8'h08;
  localparam logic [7:0] ADDR_PROG0   = 8'h0c;
  localparam logic [7:0] ADDR_PROG1   = 8'h10;
  localparam logic [7:0] ADDR_COMMAND = 8'h14;

  // First byte field positions
  localparam int BIT_HALT_RST = 7;
  localparam int BIT_WDG_ACT  = 6;
  localparam int VD_LSB       = 4;
  localparam int SEC_LSB      = 2;
  localparam int BIT_RDP      = 1;
  localparam int BIT_WRP      = 0;
  // Second byte field positions
  localparam int BIT_PORTC_IRQ_MAPPING    = 7;
  localparam int BIT_CSS      = 6;
  localparam int OSCT_LSB     = 4;
  localparam int RNG_LSB      = 1;
  localparam int BIT_PLL      = 0;

  // Status register bit positions
  localparam int ST_PROG_MODE = 0;
  localparam int ST_CFG_VALID = 1;
  localparam int ST_BUSY      = 2;
  localparam int ST_PLL_MISUSE = 3;

  // Blank option bytes, internal RC selected
  localparam logic [7:0] OPT0_BLANK = 8'hfc;
  localparam logic [7:0] OPT1_BLANK = 8'hef;

  // Field encodings
  localparam logic [1:0] VD_OFF      = 2'h3;
  localparam logic [1:0] VD_LOWEST   = 2'h2;
  localparam logic [1:0] VD_MEDIUM   = 2'h1;
  localparam logic [1:0] VD_HIGHEST  = 2'h0;
  localparam logic [1:0] OSC_RESON   = 2'h0;
  localparam logic [1:0] OSC_RSVD    = 2'h1;
  localparam logic [1:0] OSC_RC      = 2'h2;
  localparam logic [1:0] OSC_EXT     = 2'h3;
  localparam logic [2:0] BAND_MP     = 3'h1;
  localparam logic [12:0] SECTOR_MIN_BYTES = 13'h0200;

  // Cycles after reset release before the bytes are captured
  localparam logic [2:0] SETTLE_CYC  = 3'h4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    NV_IDLE,
    NV_MEM_ERASE,
    NV_OPT_ERASE,
    NV_OPT_WRITE
  } nv_state_e;

endpackage : option_cfg_pkg

// ---- rtl/option_byte_sampler.sv ----
// Captures the two option bytes once after reset release
`timescale 1ns/1ps
`default_nettype none
module option_byte_sampler
  import option_cfg_pkg::*;
#(
  parameter bit         MASK_CODED = 1'b0,
  parameter logic [7:0] MASK_OPT0  = OPT0_BLANK,
  parameter logic [7:0] MASK_OPT1  = OPT1_BLANK
) (
  input  wire logic       core_clk, // System clock
  input  wire logic       rst,      // Async reset, active high
  input  wire logic [7:0] nvOpt0,   // Stored first byte, async
  input  wire logic [7:0] nvOpt1,   // Stored second byte, async
  output logic      [7:0] opt0,     // Captured first byte
  output logic      [7:0] opt1,     // Captured second byte
  output logic            cfgValid  // Capture done
);

  logic [15:0] syncA_r;
  logic [15:0] syncB_r;
  logic [2:0]  settle_r;
  logic [7:0]  opt0_r;
  logic [7:0]  opt1_r;
  logic        valid_r;
  wire         capture = !valid_r && (settle_r == SETTLE_CYC);
  // Mask parts ignore the array and use fixed values
  wire  [7:0]  src0 = MASK_CODED ? MASK_OPT0 : syncB_r[7:0];
  wire  [7:0]  src1 = MASK_CODED ? MASK_OPT1 : syncB_r[15:8];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      syncA_r  <= 16'h0000;
      syncB_r  <= 16'h0000;
      settle_r <= 3'h0;
      opt0_r   <= OPT0_BLANK;
      opt1_r   <= OPT1_BLANK;
      valid_r  <= 1'b0;
    end else begin
      syncA_r <= {nvOpt1, nvOpt0};
      syncB_r <= syncA_r;
      if (!valid_r) begin
        settle_r <= settle_r + 3'h1;
      end
      // Taken once, held until next reset
      if (capture) begin
        opt0_r  <= src0;
        opt1_r  <= src1;
        valid_r <= 1'b1;
      end
    end
  end

  assign opt0     = opt0_r;
  assign opt1     = opt1_r;
  assign cfgValid = valid_r;

endmodule : option_byte_sampler
`default_nettype wire

// ---- rtl/option_byte_config_decoder.sv ----
// Option byte decoder with programming-mode access over AXI4-Lite
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module option_byte_config_decoder
  import option_cfg_pkg::*;
#(
  parameter bit         MASK_CODED = 1'b0,
  parameter logic [7:0] MASK_OPT0  = OPT0_BLANK,
  parameter logic [7:0] MASK_OPT1  = OPT1_BLANK
) (
  input  wire logic        core_clk,          // System clock
  input  wire logic        rst,               // Async reset, active high
  input  wire logic [7:0]  s_axi_awaddr,      // Write address
  input  wire logic        s_axi_awvalid,     // Write address valid
  output logic             s_axi_awready,     // Write address ready
  input  wire logic [31:0] s_axi_wdata,       // Write data
  input  wire logic [3:0]  s_axi_wstrb,       // Write strobes
  input  wire logic        s_axi_wvalid,      // Write data valid
  output logic             s_axi_wready,      // Write data ready
  output logic [1:0]       s_axi_bresp,       // Write response
  output logic             s_axi_bvalid,      // Write response valid
  input  wire logic        s_axi_bready,      // Write response ready
  input  wire logic [7:0]  s_axi_araddr,      // Read address
  input  wire logic        s_axi_arvalid,     // Read address valid
  output logic             s_axi_arready,     // Read address ready
  output logic [31:0]      s_axi_rdata,       // Read data
  output logic [1:0]       s_axi_rresp,       // Read response
  output logic             s_axi_rvalid,      // Read data valid
  input  wire logic        s_axi_rready,      // Read data ready
  input  wire logic        progModePin,       // Programming mode, async
  input  wire logic        userMode,          // Core in user mode
  input  wire logic        iapMode,           // Core in IAP mode
  input  wire logic [7:0]  nvOpt0,            // Stored first byte
  input  wire logic [7:0]  nvOpt1,            // Stored second byte
  output logic             nvWrReq,           // Program option byte
  output logic             nvWrSel,           // Byte index to program
  output logic [7:0]       nvWrData,          // Byte value to program
  output logic             nvEraseReq,        // Erase both option bytes
  input  wire logic        nvDone,            // Array finished request
  output logic             progMemEraseReq,   // Erase program memory
  input  wire logic        progMemEraseDone,  // Program memory erased
  output logic             progMemAccessOk,   // Program memory readable
  output logic             progMemWriteOk,    // Program memory writable
  output logic             cfgValid,          // Configuration captured
  output logic             haltWatchdogReset, // Reset on halt entry
  output logic             watchdogHwEnable,  // Watchdog forced on
  output logic             detectorEnable,    // Supply detectors on
  output logic [1:0]       voltageDetectLevel, // Threshold code
  output logic [12:0]      sectorZeroBytes,   // Sector zero size
  output logic             readoutProtect,    // Read-out protection
  output logic             writeProtectLock,  // Write lock
  output logic             portcOnVectorB,    // Port C on second vector
  output logic             clockSafetyEnable, // Filter and backup osc
  output logic [1:0]       oscSourceSel,      // Clock source code
  output logic             oscSourceReserved, // Reserved source code
  output logic [2:0]       oscBandSel,        // Frequency band code
  output logic             oscVeryLowPower,   // 32 to 100 kHz band
  output logic             pllEnable          // Frequency doubler on
);

  logic [7:0] opt0;
  logic [7:0] opt1;
  logic       progSyncA_r;
  logic       progSyncB_r;

  option_byte_sampler #(
    .MASK_CODED (MASK_CODED),
    .MASK_OPT0  (MASK_OPT0),
    .MASK_OPT1  (MASK_OPT1)
  ) u_sampler (
    .core_clk (core_clk),
    .rst      (rst),
    .nvOpt0   (nvOpt0),
    .nvOpt1   (nvOpt1),
    .opt0     (opt0),
    .opt1     (opt1),
    .cfgValid (cfgValid)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      progSyncA_r <= 1'b0;
      progSyncB_r <= 1'b0;
    end else begin
      progSyncA_r <= progModePin;
      progSyncB_r <= progSyncA_r;
    end
  end

  wire progMode = progSyncB_r;

  // Decoded configuration
  assign haltWatchdogReset  = opt0[BIT_HALT_RST];
  assign watchdogHwEnable   = !opt0[BIT_WDG_ACT];
  assign voltageDetectLevel = opt0[VD_LSB +: 2];
  assign detectorEnable     = voltageDetectLevel != VD_OFF;
  assign sectorZeroBytes    = SECTOR_MIN_BYTES << opt0[SEC_LSB +: 2];
  assign readoutProtect     = opt0[BIT_RDP];
  assign writeProtectLock   = opt0[BIT_WRP];
  assign portcOnVectorB     = opt1[BIT_PORTC_IRQ_MAPPING];
  assign clockSafetyEnable  = !opt1[BIT_CSS];
  assign oscSourceSel       = opt1[OSCT_LSB +: 2];
  assign oscSourceReserved  = oscSourceSel == OSC_RSVD;
  assign oscBandSel         = opt1[RNG_LSB +: 3];
  assign oscVeryLowPower    = oscBandSel[2];
  assign pllEnable          = !opt1[BIT_PLL];

  // Doubler outside its band is flagged, not corrected
  wire pllMisuse = pllEnable && (oscBandSel != BAND_MP);

  assign progMemAccessOk = !readoutProtect || userMode || iapMode;
  assign progMemWriteOk  = !writeProtectLock;

  // Write channel
  logic        awHeld_r;
  logic        wHeld_r;
  logic [7:0]  awAddr_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic        bValid_r;
  logic [1:0]  bResp_r;
  logic        rValid_r;
  logic [1:0]  rResp_r;
  logic [31:0] rData_r;
  nv_state_e   state_r;
  nv_state_e   state_nxt;
  logic        wrSel_r;
  logic [7:0]  wrData_r;

  assign s_axi_awready = !awHeld_r && !bValid_r;
  assign s_axi_wready  = !wHeld_r && !bValid_r;
  assign s_axi_arready = !rValid_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rresp   = rResp_r;
  assign s_axi_rdata   = rData_r;

  wire doWrite  = awHeld_r && wHeld_r && !bValid_r;
  wire idle     = state_r == NV_IDLE;
  wire lowLane  = wStrb_r[0];
  wire isProg0  = awAddr_r == ADDR_PROG0;
  wire isProg1  = awAddr_r == ADDR_PROG1;
  wire isCmd    = awAddr_r == ADDR_COMMAND;
  wire eraseCmd = isCmd && lowLane && wData_r[0];
  // Only reachable in programming mode and while idle
  wire wrAccept = progMode && idle && (isProg0 || isProg1 || isCmd)
                  && !(eraseCmd && writeProtectLock);
  wire startProg  = doWrite && wrAccept && lowLane && (isProg0 || isProg1);
  wire startErase = doWrite && wrAccept && eraseCmd;
  // Locked bit can never return to zero
  wire [7:0] progByte = isProg0
    ? (wData_r[7:0] | {7'h00, writeProtectLock})
    : wData_r[7:0];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
      bValid_r <= 1'b0;
      bResp_r  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bValid_r <= 1'b1;
        bResp_r  <= wrAccept ? RESP_OKAY : RESP_SLVERR;
      end else if (bValid_r && s_axi_bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  // Read channel
  wire [31:0] statusWord = {28'h0000000, pllMisuse, !idle, cfgValid,
                            progMode};
  wire rdIsStatus = s_axi_araddr == ADDR_STATUS;
  wire rdIsOpt0   = s_axi_araddr == ADDR_OPT0;
  wire rdIsOpt1   = s_axi_araddr == ADDR_OPT1;
  // Option bytes hidden outside programming mode
  wire rdOk = rdIsStatus || (progMode && (rdIsOpt0 || rdIsOpt1));
  wire [31:0] rdMux = rdIsStatus ? statusWord
                    : !rdOk      ? 32'h0000_0000
                    : rdIsOpt0   ? {24'h000000, opt0}
                    :              {24'h000000, opt1};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rValid_r <= 1'b0;
      rResp_r  <= RESP_OKAY;
      rData_r  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_r <= 1'b1;
      rResp_r  <= rdOk ? RESP_OKAY : RESP_SLVERR;
      rData_r  <= rdMux;
    end else if (rValid_r && s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  // Non-volatile request sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      NV_IDLE: begin
        if (startErase) begin
          // Protected content goes before the options do
          state_nxt = readoutProtect ? NV_MEM_ERASE : NV_OPT_ERASE;
        end else if (startProg) begin
          state_nxt = NV_OPT_WRITE;
        end
      end
      NV_MEM_ERASE: begin
        if (progMemEraseDone) begin
          state_nxt = NV_OPT_ERASE;
        end
      end
      NV_OPT_ERASE: begin
        if (nvDone) begin
          state_nxt = NV_IDLE;
        end
      end
      NV_OPT_WRITE: begin
        if (nvDone) begin
          state_nxt = NV_IDLE;
        end
      end
      default: begin
        state_nxt = NV_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r  <= NV_IDLE;
      wrSel_r  <= 1'b0;
      wrData_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (startProg) begin
        wrSel_r  <= isProg1;
        wrData_r <= progByte;
      end
    end
  end

  assign nvWrReq         = state_r == NV_OPT_WRITE;
  assign nvWrSel         = wrSel_r;
  assign nvWrData        = wrData_r;
  assign nvEraseReq      = state_r == NV_OPT_ERASE;
  assign progMemEraseReq = state_r == NV_MEM_ERASE;

endmodule : option_byte_config_decoder
`default_nettype wire

// ---- tb/option_nv_model.sv ----
// Option byte array and program memory stand-in
`timescale 1ns/1ps
`default_nettype none
module option_nv_model
  import option_cfg_pkg::*;
(
  input  wire logic       core_clk,         // Clock
  input  wire logic       rst,              // Clears busy count
  input  wire logic       nvSlow,           // Long busy time
  input  wire logic       nvWrReq,          // Byte program
  input  wire logic       nvWrSel,          // Byte index
  input  wire logic [7:0] nvWrData,         // Byte value
  input  wire logic       nvEraseReq,       // Option erase
  input  wire logic       progMemEraseReq,  // Memory erase
  output logic            nvDone,           // Request done
  output logic            progMemEraseDone, // Memory erased
  output logic      [7:0] nvOpt0,           // First byte
  output logic      [7:0] nvOpt1,           // Second byte
  output logic            memErased         // Memory wiped once
);
  logic [3:0] cnt_r;
  logic       busy;
  logic       fin;
  initial begin
    nvOpt0 = OPT0_BLANK;
    nvOpt1 = OPT1_BLANK;
    memErased = 1'b0;
    cnt_r = 4'h0;
  end
  assign busy = nvWrReq | nvEraseReq | progMemEraseReq;
  assign fin = busy && cnt_r == (nvSlow ? 4'hc : 4'h2);
  assign nvDone = fin & ~progMemEraseReq;
  assign progMemEraseDone = fin & progMemEraseReq;
  always @(posedge core_clk) begin
    if (rst || fin || !busy) cnt_r <= 4'h0;
    else cnt_r <= cnt_r + 4'h1;
    if (fin && nvEraseReq) begin
      nvOpt0 <= 8'hff;
      nvOpt1 <= 8'hff;
    end
    if (fin && nvWrReq && !nvWrSel) nvOpt0 <= nvWrData;
    if (fin && nvWrReq && nvWrSel) nvOpt1 <= nvWrData;
    if (progMemEraseDone) memErased <= 1'b1;
  end
endmodule : option_nv_model
`default_nettype wire

// ---- tb/option_byte_config_decoder_assertions.sv ----
// Port assertions for the option byte decoder
`timescale 1ns/1ps
`default_nettype none
module option_byte_config_decoder_assertions
  import option_cfg_pkg::*;
(
  input wire logic       core_clk,           // Clock
  input wire logic       rst,                // Reset
  input wire logic       s_axi_bvalid,       // Write resp
  input wire logic [1:0] s_axi_bresp,        // Resp code
  input wire logic       progModePin,        // Prog mode
  input wire logic       userMode,           // User mode
  input wire logic       iapMode,            // IAP mode
  input wire logic       readoutProtect,     // Read lock
  input wire logic       writeProtectLock,   // Write lock
  input wire logic       progMemAccessOk,    // Read ok
  input wire logic       progMemWriteOk,     // Write ok
  input wire logic       nvEraseReq,         // Opt erase
  input wire logic       progMemEraseReq,    // Mem erase
  input wire logic       progMemEraseDone,   // Mem erased
  input wire logic       nvWrReq,            // Byte prog
  input wire logic       nvWrSel,            // Byte index
  input wire logic [7:0] nvWrData,           // Byte value
  input wire logic       cfgValid,           // Captured
  input wire logic       detectorEnable,     // Detectors on
  input wire logic [1:0] voltageDetectLevel, // Threshold
  input wire logic [1:0] oscSourceSel,       // Clock source
  input wire logic       oscSourceReserved   // Reserved code
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_hold; cfgValid && $past(cfgValid) |-> $stable({readoutProtect,
    writeProtectLock, voltageDetectLevel, oscSourceSel}); endproperty
  a_hold: assert property (p_hold) else $error("config moved");
  property p_det; detectorEnable == (voltageDetectLevel != VD_OFF);
  endproperty
  a_det: assert property (p_det) else $error("detector enable");
  property p_rdp;
    progMemAccessOk == (!readoutProtect || userMode || iapMode); endproperty
  a_rdp: assert property (p_rdp) else $error("read access");
  property p_wp; progMemWriteOk == !writeProtectLock; endproperty
  a_wp: assert property (p_wp) else $error("write access");
  property p_nolock; writeProtectLock |-> !nvEraseReq && !progMemEraseReq;
  endproperty
  a_nolock: assert property (p_nolock) else $error("locked erase");
  property p_order;
    $rose(nvEraseReq) && readoutProtect |-> $past(progMemEraseDone);
  endproperty
  a_order: assert property (p_order) else $error("erase order");
  property p_osc; oscSourceReserved == (oscSourceSel == OSC_RSVD); endproperty
  a_osc: assert property (p_osc) else $error("reserved source");
  property p_lockbit;
    nvWrReq && !nvWrSel && writeProtectLock |-> nvWrData[0]; endproperty
  a_lockbit: assert property (p_lockbit) else $error("lock bit");
  property p_prog; !progModePin [*4] ##0 $rose(s_axi_bvalid) |->
    s_axi_bresp == RESP_SLVERR; endproperty
  a_prog: assert property (p_prog) else $error("write outside");
endmodule : option_byte_config_decoder_assertions
bind option_byte_config_decoder option_byte_config_decoder_assertions chk (.*);
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the option byte decoder
`timescale 1ns/1ps
`default_nettype none
module testbench
  import option_cfg_pkg::*;
();
  logic        core_clk, rst, progModePin, userMode, iapMode, nvSlow;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, nvOpt0, nvOpt1, nvWrData;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, voltageDetectLevel, oscSourceSel, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, nvWrReq, nvWrSel, nvEraseReq;
  logic        nvDone, progMemEraseReq, progMemEraseDone, progMemAccessOk;
  logic        progMemWriteOk, cfgValid, haltWatchdogReset, watchdogHwEnable;
  logic        detectorEnable, readoutProtect, writeProtectLock, memErased;
  logic        portcOnVectorB, clockSafetyEnable, oscSourceReserved;
  logic        oscVeryLowPower, pllEnable;
  logic [12:0] sectorZeroBytes, mSector;
  logic [1:0]  mOsc;
  logic [2:0]  oscBandSel;
  int          n_fail, total_checks;
  option_byte_config_decoder dut (.*);
  option_nv_model nv (.*);
  // Mask-coded variant, bus idle, only its decode is watched
  option_byte_config_decoder #(
    .MASK_CODED (1'b1),
    .MASK_OPT0  (8'h36),
    .MASK_OPT1  (8'hc9)
  ) dutMask (
    .*,
    .s_axi_awvalid (1'b0), .s_axi_wvalid (1'b0), .s_axi_arvalid (1'b0),
    .s_axi_awready (), .s_axi_wready (), .s_axi_bresp (), .s_axi_bvalid (),
    .s_axi_arready (), .s_axi_rdata (), .s_axi_rresp (), .s_axi_rvalid (),
    .nvWrReq (), .nvWrSel (), .nvWrData (), .nvEraseReq (),
    .progMemEraseReq (), .progMemAccessOk (), .progMemWriteOk (),
    .cfgValid (), .haltWatchdogReset (), .watchdogHwEnable (),
    .detectorEnable (), .voltageDetectLevel (), .sectorZeroBytes (mSector),
    .readoutProtect (), .writeProtectLock (), .portcOnVectorB (),
    .clockSafetyEnable (), .oscSourceSel (mOsc), .oscSourceReserved (),
    .oscBandSel (), .oscVeryLowPower (), .pllEnable ()
  );
  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;
  task automatic cmp(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic close_out;
    $display("Checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge core_clk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    logic ta, tr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge core_clk);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask : rdr
  task automatic do_reset;
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    cmp("cfgValid", 32'h1, cfgValid);
  endtask : do_reset
  task automatic wait_idle;
    rd = 32'h4;
    while (rd[2] !== 1'b0) rdr(ADDR_STATUS);
  endtask : wait_idle
  task automatic chk_cfg(input logic [7:0] a, b);
    cmp("haltRst", a[7], haltWatchdogReset);
    cmp("wdgHw", !a[6], watchdogHwEnable);
    cmp("vdLevel", a[5:4], voltageDetectLevel);
    cmp("detEn", a[5:4] != 2'h3, detectorEnable);
    cmp("sector", 32'h200 << a[3:2], sectorZeroBytes);
    cmp("rdp", a[1], readoutProtect);
    cmp("wrLock", a[0], writeProtectLock);
    cmp("portC", b[7], portcOnVectorB);
    cmp("css", !b[6], clockSafetyEnable);
    cmp("oscSrc", b[5:4], oscSourceSel);
    cmp("oscRsvd", b[5:4] == 2'h1, oscSourceReserved);
    cmp("band", b[3:1], oscBandSel);
    cmp("vlp", b[3], oscVeryLowPower);
    cmp("pll", !b[0], pllEnable);
  endtask : chk_cfg
  task automatic t_blank;
    chk_cfg(OPT0_BLANK, OPT1_BLANK);
    cmp("rcBlank", 32'h2, oscSourceSel);
    cmp("maskSector", 32'h400, mSector);
    cmp("maskOsc", OSC_RESON, mOsc);
    rdr(ADDR_OPT0);
    cmp("optRdResp", RESP_SLVERR, rsp);
    cmp("optRdData", 32'h0, rd);
    wr(ADDR_PROG0, 32'h0);
    cmp("progResp", RESP_SLVERR, rsp);
    cmp("arrayKept", OPT0_BLANK, nvOpt0);
    $display("t_blank done");
  endtask : t_blank
  task automatic t_prog(input logic [7:0] a, b);
    progModePin <= 1'b1;
    repeat (3) @(posedge core_clk);
    wr(ADDR_PROG0, {24'h0, a});
    cmp("prog0Resp", RESP_OKAY, rsp);
    if (nvSlow) begin
      wr(ADDR_PROG1, {24'h0, b});
      cmp("busyResp", RESP_SLVERR, rsp);
    end
    wait_idle();
    wr(ADDR_PROG1, {24'h0, b});
    wait_idle();
    cmp("array0", a, nvOpt0);
    do_reset();
    chk_cfg(a, b);
    rdr(ADDR_OPT1);
    cmp("opt1Rd", b, rd);
    rdr(ADDR_STATUS);
    cmp("status", {28'h0, !b[0] && b[3:1] != 3'h1, 3'h3}, rd);
    $display("t_prog done");
  endtask : t_prog
  task automatic t_rdp;
    for (int i = 0; i < 4; i++) begin
      userMode <= i[0];
      iapMode <= i[1];
      @(negedge core_clk);
      cmp("memAccess", i != 0, progMemAccessOk);
      @(posedge core_clk);
    end
    cmp("memBefore", 32'h0, memErased);
    wr(ADDR_COMMAND, 32'h1);
    wait_idle();
    cmp("memAfter", 32'h1, memErased);
    do_reset();
    chk_cfg(8'hff, 8'hff);
    $display("t_rdp done");
  endtask : t_rdp
  task automatic t_lock;
    t_prog(8'hf1, 8'hf8);
    cmp("memWrite", 32'h0, progMemWriteOk);
    wr(ADDR_COMMAND, 32'h1);
    cmp("eraseResp", RESP_SLVERR, rsp);
    wr(ADDR_PROG0, 32'h0);
    wait_idle();
    cmp("lockKept", 32'h1, nvOpt0);
    $display("t_lock done");
  endtask : t_lock
  initial begin
    {rst, progModePin, userMode, iapMode, nvSlow} = 5'h10;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    do_reset();
    t_blank();
    nvSlow <= 1'b1;
    t_prog(8'h00, 8'h02);
    nvSlow <= 1'b0;
    t_prog(8'h54, 8'h94);
    t_prog(8'haa, 8'h67);
    t_rdp();
    t_lock();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
